// *** bench/return_and_noop_execution_bench.sv ***
// self-checking bench for the return and no-operation slice
// assumes one 50 MHz clock; status flags live outside the slice
`timescale 1ns/1ps
module return_and_noop_execution_bench;
    import return_noop_pkg::*;
    typedef struct {
        logic [12:0] pc;
        logic [7:0]  w;
        logic [7:0]  icr;
        logic        pop;
        logic        unk;
    } note_type;
    logic        clk;
    logic        rstn = 1'b0;
    logic        instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [12:0] top_of_stack = 13'h0000;
    logic        interrupt_enable_clear = 1'b0;
    logic        instr_ready;
    logic        stack_pop;
    logic [12:0] pc;
    logic [7:0]  w;
    logic [7:0]  icr;
    logic        unknown_op;
    note_type    notes[$];
    note_type    m;
    note_type    n;
    int          num_errors = 0;
    int          n_tests = 0;
    int          seed = 32'ha9fd011a;
    logic [31:0] r;
    logic        took;
    return_noop_exec dut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .top_of_stack(top_of_stack), .stack_pop(stack_pop),
        .interrupt_enable_clear(interrupt_enable_clear), .pc(pc), .w(w),
        .interrupt_control_register(icr), .unknown_op(unknown_op));
    ////////////////////////////////////////////////////////////////////////////
    task automatic compare(input string what, input logic [12:0] e, input logic [12:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // every return also offers a word in its busy cycle, which must be refused
    task automatic go(input logic [13:0] i, input logic [12:0] t, input logic c);
        logic ret;
        @(negedge clk);
        instr_valid = 1'b1;
        instr = i;
        top_of_stack = t;
        interrupt_enable_clear = c;
        ret = (i == return_from_int_code) || (i[13:10] == return_literal_code);
        m.pop = ret;
        m.unk = !ret && ((i & no_operation_mask) != no_operation_code);
        if (c) m.icr[interrupt_enable_bit] = 1'b0;
        if (i == return_from_int_code) m.icr[interrupt_enable_bit] = 1'b1;
        if (i[13:10] == return_literal_code) m.w = i[7:0];
        m.pc = ret ? t : m.pc + pc_step;
        notes.push_back(m);
        if (ret) begin
            @(negedge clk);
            compare("instr_ready", 13'h0, {12'h0, instr_ready});
            instr = 14'h0000;
            interrupt_enable_clear = 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #40000;
        num_errors++;
        print_verdict();
    end
    // monitor: a taken word yields one note; idle cycles must hold pc, w and icr with no pop or unknown_op
    initial begin
        forever begin
            // the take is judged just before the edge, clear of driver and update
            @(negedge clk);
            #8;
            took = instr_valid && instr_ready && rstn;
            @(posedge clk);
            #2;
            if (took) n = notes.pop_front();
            else begin
                n.pop = 1'b0;
                n.unk = 1'b0;
            end
            if (rstn) begin
                compare("pc", n.pc, pc);
                compare("w", {5'h0, n.w}, {5'h0, w});
                compare("icr", {5'h0, n.icr}, {5'h0, icr});
                compare("stack_pop", {12'h0, n.pop}, {12'h0, stack_pop});
                compare("unknown_op", {12'h0, n.unk}, {12'h0, unknown_op});
            end
        end
    end
    initial begin
        m = '{pc_reset, w_reset, interrupt_control_reset, 1'b0, 1'b0};
        n = m;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        for (int k = 0; k < 4; k++) go(14'(k << 5), 13'h1abc, 1'b0);
        go(return_from_int_code, 13'h1fff, 1'b1);
        go(14'h0040, 13'h0000, 1'b1);
        go(14'h3400, 13'h0155, 1'b0);
        go(14'h37ff, 13'h1234, 1'b0);
        go(return_from_int_code, 13'h0005, 1'b0);
        go(14'h0062, 13'h0abc, 1'b0);
        // random mix: the slice must never drift on flags it does not own
        repeat (300) begin
            r = $random(seed);
            case (r[31:30])
                2'd0: go({7'h00, r[6:5], 5'h00}, r[22:10], r[23]);
                2'd1: go(return_from_int_code, r[22:10], r[23]);
                2'd2: go({4'hd, r[9:0]}, r[22:10], r[23]);
                default: go(r[13:0], r[27:15], r[28]);
            endcase
        end
        @(negedge clk);
        instr_valid = 1'b0;
        interrupt_enable_clear = 1'b0;
        repeat (3) @(posedge clk);
        #5;
        compare("notes left", 13'h0, 13'(notes.size()));
        print_verdict();
    end
endmodule

// *** hw/opcode_classify.sv ***
// opcode classifier for the three instructions handled by this slice
// assumes the instruction word is stable while it is presented
`timescale 1ns/1ps
module opcode_classify
    import return_noop_pkg::*;
(
    input  wire logic [13:0] instr,
    output logic             is_no_operation,
    output logic             is_return_from_interrupt,
    output logic             is_return_with_literal
);
    always_comb begin
        is_no_operation          = (instr & no_operation_mask) == no_operation_code; // RULE7
        is_return_from_interrupt = instr == return_from_int_code;                    // RULE1
        is_return_with_literal   = instr[13:10] == return_literal_code;              // RULE4
    end
endmodule

// *** hw/return_noop_exec.sv ***
// execution of no-operation, return from interrupt and return with literal
// assumes instruction words and the stack top come from logic on clk;
// the stack itself pops on stack_pop, and status flags live elsewhere
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - return from interrupt pops stack into pc
// RULE2 - return from interrupt sets global interrupt enable
// RULE3 - return from interrupt: two cycles, flags untouched
// RULE4 - return with literal loads literal into w
// RULE5 - return with literal pops stack into pc
// RULE6 - return with literal takes two cycles
// RULE7 - no-operation: one cycle, pc plus one
module return_noop_exec
    import return_noop_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    output logic             instr_ready,
    input  wire logic [12:0] top_of_stack,
    output logic             stack_pop,
    input  wire logic        interrupt_enable_clear,
    output logic [12:0]      pc,
    output logic [7:0]       w,
    output logic [7:0]       interrupt_control_register,
    output logic             unknown_op
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        exec_state   = 2'b01,
        second_state = 2'b10
    } phase_type;

    typedef struct packed {
        phase_type   phase;
        logic [12:0] pc;
        logic [7:0]  w;
        logic        interrupt_enable;
        logic        pop;
        logic        unknown;
    } state_type;

    state_type   st;
    state_type   next_st;
    logic        is_no_operation;
    logic        is_return_from_interrupt;
    logic        is_return_with_literal;
    logic        take;

    opcode_classify u_classify (
        .instr                    (instr),
        .is_no_operation          (is_no_operation),
        .is_return_from_interrupt (is_return_from_interrupt),
        .is_return_with_literal   (is_return_with_literal)
    );

    ////////////////////////////////////////////////////////////////////////////
    // a word is only taken in the first cycle; the second cycle of a return
    // is the refill slot, so the fetch side is held off there
    assign instr_ready = st.phase == exec_state;
    assign take        = instr_valid && instr_ready;

    always_comb begin
        next_st         = st;
        next_st.pop     = 1'b0;
        next_st.unknown = 1'b0;
        // a clear from interrupt entry loses to a set in the same cycle
        if (interrupt_enable_clear) begin
            next_st.interrupt_enable = 1'b0;
        end
        unique case (st.phase)
            exec_state: begin
                if (take) begin
                    if (is_return_from_interrupt) begin
                        next_st.pc               = top_of_stack; // RULE1
                        next_st.pop              = 1'b1;         // RULE1
                        next_st.interrupt_enable = 1'b1;         // RULE2
                        next_st.phase            = second_state; // RULE3
                    end else if (is_return_with_literal) begin
                        next_st.w     = instr[literal_msb:literal_lsb]; // RULE4
                        next_st.pc    = top_of_stack; // RULE5
                        next_st.pop   = 1'b1;         // RULE5
                        next_st.phase = second_state; // RULE6
                    end else begin
                        // other words belong to other units; pc steps, and unknown_op flags all but no-operation
                        // the carry out of the top bit is dropped, so pc wraps to zero
                        next_st.pc      = 13'(st.pc + pc_step); // RULE7
                        next_st.unknown = !is_no_operation;
                    end
                end
            end
            second_state: begin
                next_st.phase = exec_state; // RULE3 RULE6
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{phase: exec_state, pc: pc_reset, w: w_reset,
                    interrupt_enable: interrupt_control_reset[interrupt_enable_bit],
                    pop: 1'b0, unknown: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // no status flag port exists: flags cannot be touched by these words
    always_comb begin
        interrupt_control_register                       = interrupt_control_reset;
        interrupt_control_register[interrupt_enable_bit] = st.interrupt_enable;
    end
    assign pc         = st.pc;
    assign w          = st.w;
    assign stack_pop  = st.pop;
    assign unknown_op = st.unknown;

    ////////////////////////////////////////////////////////////////////////////
    // checks watch the ports, so they hold whatever the stack and fetch side do
    property p_return_interrupt_pc;
        @(posedge clk) disable iff (!rstn)
        take && is_return_from_interrupt |=> pc == $past(top_of_stack) && stack_pop;
    endproperty
    a_return_interrupt_pc: assert property (p_return_interrupt_pc) // RULE1
        else $error("return from interrupt did not load pc from stack");

    // a clear in the refill cycle comes from interrupt entry and may win there
    property p_return_interrupt_enable;
        @(posedge clk) disable iff (!rstn)
        take && is_return_from_interrupt |=>
            interrupt_control_register[interrupt_enable_bit] ##1
            (interrupt_control_register[interrupt_enable_bit] || $past(interrupt_enable_clear));
    endproperty
    a_return_interrupt_enable: assert property (p_return_interrupt_enable) // RULE2
        else $error("global interrupt enable not set by return from interrupt");

    property p_enable_set_wins;
        @(posedge clk) disable iff (!rstn)
        take && is_return_from_interrupt && interrupt_enable_clear |=>
            interrupt_control_register[interrupt_enable_bit];
    endproperty
    a_enable_set_wins: assert property (p_enable_set_wins) // RULE2
        else $error("interrupt entry clear beat the return from interrupt set");

    property p_return_interrupt_two;
        @(posedge clk) disable iff (!rstn)
        take && is_return_from_interrupt |=> !instr_ready && $stable(w) ##1 instr_ready;
    endproperty
    a_return_interrupt_two: assert property (p_return_interrupt_two) // RULE3
        else $error("return from interrupt not two cycles or w changed");

    property p_return_literal_w;
        @(posedge clk) disable iff (!rstn)
        take && is_return_with_literal |=> w == $past(instr[literal_msb:literal_lsb]);
    endproperty
    a_return_literal_w: assert property (p_return_literal_w) // RULE4
        else $error("literal not loaded into w");

    property p_w_only_literal;
        @(posedge clk) disable iff (!rstn)
        !(take && is_return_with_literal) |=> $stable(w);
    endproperty
    a_w_only_literal: assert property (p_w_only_literal) // RULE4
        else $error("w changed without a return with literal");

    property p_return_literal_pc;
        @(posedge clk) disable iff (!rstn)
        take && is_return_with_literal |=> pc == $past(top_of_stack) && stack_pop ##1 !stack_pop;
    endproperty
    a_return_literal_pc: assert property (p_return_literal_pc) // RULE5
        else $error("return with literal did not pop stack into pc once");

    property p_return_literal_two;
        @(posedge clk) disable iff (!rstn)
        take && is_return_with_literal |=> !instr_ready ##1 instr_ready && $stable(pc);
    endproperty
    a_return_literal_two: assert property (p_return_literal_two) // RULE6
        else $error("return with literal not two cycles");

    // the refill slot lasts exactly one cycle, or the fetch side would stall
    property p_ready_returns;
        @(posedge clk) disable iff (!rstn)
        !instr_ready |=> instr_ready;
    endproperty
    a_ready_returns: assert property (p_ready_returns) // RULE3 RULE6
        else $error("fetch side held off for more than one cycle");

    property p_no_operation;
        @(posedge clk) disable iff (!rstn)
        take && is_no_operation |=> pc == 13'($past(pc) + pc_step) && $stable(w)
            && !stack_pop && instr_ready && !unknown_op;
    endproperty
    a_no_operation: assert property (p_no_operation) // RULE7
        else $error("no-operation did something besides pc plus one");

    property p_other_word;
        @(posedge clk) disable iff (!rstn)
        take && !is_no_operation && !is_return_from_interrupt && !is_return_with_literal |=>
            unknown_op && !stack_pop && pc == 13'($past(pc) + pc_step) && $stable(w);
    endproperty
    a_other_word: assert property (p_other_word) // RULE7
        else $error("foreign word did more than flag itself and step pc");

    property p_pc_only_taken;
        @(posedge clk) disable iff (!rstn)
        !take |=> $stable(pc);
    endproperty
    a_pc_only_taken: assert property (p_pc_only_taken) // RULE1 RULE5 RULE7
        else $error("pc moved without a taken word");

    property p_pop_pulse;
        @(posedge clk) disable iff (!rstn)
        stack_pop |=> !stack_pop;
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) // RULE1 RULE5
        else $error("stack pop held for more than one cycle");

    property p_pop_only_on_return;
        @(posedge clk) disable iff (!rstn)
        $rose(stack_pop) |->
            $past(take && (is_return_from_interrupt || is_return_with_literal));
    endproperty
    a_pop_only_on_return: assert property (p_pop_only_on_return) // RULE1 RULE5
        else $error("stack popped without a return word");
endmodule

// *** hw/return_noop_pkg.sv ***
// constants for the return and no-operation execution slice of the core
// assumes a 14-bit instruction word and a 13-bit program counter
package return_noop_pkg;
    localparam int          instr_width      = 14;
    localparam int          pc_width         = 13;
    localparam int          data_width       = 8;
    localparam int          interrupt_enable_bit = 7;
    // no-operation: 00 0000 0xx0 0000, bits 6 and 5 are don't-care
    localparam logic [13:0] no_operation_mask  = 14'h3f9f;
    localparam logic [13:0] no_operation_code  = 14'h0000;
    localparam logic [13:0] return_from_int_code = 14'h0009;
    // return with literal: upper nibble 11 01, then xx and the literal
    localparam logic [3:0]  return_literal_code = 4'hd;
    localparam int          literal_lsb      = 0;
    localparam int          literal_msb      = 7;
    localparam logic [12:0] pc_reset         = 13'h0000;
    localparam logic [7:0]  w_reset          = 8'h00;
    localparam logic [7:0]  interrupt_control_reset = 8'h00;
    localparam logic [12:0] pc_step          = 13'h0001;
endpackage
